// ### common/clr_pkg.sv
// Constants for the linear sensor line readout controller
package clr_pkg;
  localparam int unsigned CLK_HZ            = 40000000;
  // Transfer gate pulse width, least (ns)
  localparam int unsigned TG_PULSE_NS       = 5000;
  localparam int unsigned TG_PULSE_CYC      = (TG_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Guard from gate edges to first shift clock, least (ns)
  localparam int unsigned TG_GUARD_NS       = 900;
  localparam int unsigned TG_GUARD_CYC      = (TG_GUARD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // Half period of the shift clock (ns), 1 MHz shift clock, one pixel per period
  localparam int unsigned SHIFT_HALF_NS     = 500;
  localparam int unsigned SHIFT_HALF_CYC    = (SHIFT_HALF_NS * (CLK_HZ / 1000000)) / 1000;
  // Reset gate pulse width (ns), least
  localparam int unsigned RB_PULSE_NS       = 110;
  localparam int unsigned RB_PULSE_CYC      = (RB_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned PIX_W             = 16;
  localparam int unsigned CNT_W             = 16;
  localparam int unsigned FIFO_W            = 17;
  localparam int unsigned FIFO_D            = 8;
  localparam logic [CNT_W-1:0] PIX_RST      = 16'h29b8;
  localparam logic [2:0]  SUM_RST           = 3'h0;
  localparam logic        HIRES_RST         = 1'b1;
  localparam logic        LCLAMP_RST        = 1'b0;

  typedef enum logic [3:0] {
    CLR_IDLE  = 4'b0001,
    CLR_XFER  = 4'b0010,
    CLR_GUARD = 4'b0100,
    CLR_SHIFT = 4'b1000
  } clr_state_t;
endpackage

// ### src/clr_fifo.sv
// Small valid/ready FIFO for sampled pixel words
`timescale 1ns/10ps
`default_nettype none
module clr_fifo #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = ce && in_valid && in_ready;
  assign pop       = ce && out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/clr_ctrl.sv
// Timing generator that drives a three-colour linear sensor and collects its pixels
`timescale 1ns/10ps
`default_nettype none
module clr_ctrl (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      line_start,
  input  wire logic                      hires_req,
  input  wire logic                      line_clamp_req,
  input  wire logic                      clamp_from_tg,
  input  wire logic [2:0]                sum_log2,
  input  wire logic [clr_pkg::CNT_W-1:0] pixels_per_line,
  input  wire logic [clr_pkg::PIX_W-1:0] adc_data,
  output logic                           transfer_gate_clock_a,
  output logic                           transfer_gate_clock_b,
  output logic                           transfer_gate_clock_c,
  output logic                           shift_clock_1,
  output logic                           shift_clock_2,
  output logic                           reset_gate_clock,
  output logic                           level_clamp_clock,
  output logic                           resolution_select,
  output logic                           busy,
  output logic                           pix_valid,
  input  wire logic                      pix_ready,
  output logic [clr_pkg::PIX_W-1:0]      pix_data,
  output logic                           pix_last
);
  import clr_pkg::*;

  clr_state_t             state_reg;
  logic [CNT_W-1:0]       tmr_reg;
  logic [CNT_W-1:0]       pix_reg;
  logic [6:0]             sum_reg;
  logic                   lclamp_reg;
  logic                   drop_reg;
  logic [PIX_W-1:0]       adc_s1_reg;
  logic [PIX_W-1:0]       adc_s2_reg;
  logic                   fin_valid;
  logic                   fin_ready;
  logic [FIFO_W-1:0]      fin_data;
  logic                   fout_valid;
  logic [FIFO_W-1:0]      fout_data;
  logic                   half_end;
  logic                   sample_now;
  logic [6:0]             sum_span;

  function automatic logic [6:0] span_of(input logic [2:0] l2);
    span_of = 7'(7'h01 << l2) - 7'h01;
  endfunction

  assign sum_span   = span_of(sum_log2);
  assign half_end   = (tmr_reg == CNT_W'(SHIFT_HALF_CYC - 1));
  // Pixel is read in the last cycle of the high half of shift_clock_1, on the edge where it falls
  assign sample_now = (state_reg == CLR_SHIFT) && half_end && shift_clock_1
                      && (sum_reg == '0) && !drop_reg;
  assign fin_valid  = sample_now;
  assign fin_data   = {(pix_reg == CNT_W'(1)), adc_s2_reg};

  // ADC word comes from another domain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      adc_s1_reg <= '0;
      adc_s2_reg <= '0;
    end else if (ce) begin
      adc_s1_reg <= adc_data;
      adc_s2_reg <= adc_s1_reg;
    end
  end

  // Sequencer; output FIFO back-pressure stalls the shift clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg         <= CLR_IDLE;
      tmr_reg           <= '0;
      pix_reg           <= PIX_RST;
      sum_reg           <= '0;
      resolution_select <= HIRES_RST;
      lclamp_reg        <= LCLAMP_RST;
      drop_reg          <= 1'b0;
      busy              <= 1'b0;
    end else if (ce) begin
      case (state_reg)
        CLR_IDLE: begin
          if (line_start) begin
            if (hires_req != resolution_select) begin
              drop_reg <= 1'b1;
            end else begin
              drop_reg <= 1'b0;
            end
            resolution_select <= hires_req;
            lclamp_reg        <= line_clamp_req;
            pix_reg           <= (pixels_per_line == '0) ? CNT_W'(1) : pixels_per_line;
            tmr_reg           <= '0;
            busy              <= 1'b1;
            state_reg         <= CLR_XFER;
          end
        end
        CLR_XFER: begin
          if (tmr_reg == CNT_W'(TG_PULSE_CYC - 1)) begin
            tmr_reg   <= '0;
            state_reg <= CLR_GUARD;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        CLR_GUARD: begin
          if (tmr_reg == CNT_W'(TG_GUARD_CYC - 1)) begin
            tmr_reg   <= '0;
            sum_reg   <= resolution_select ? 7'h00 : sum_span;
            state_reg <= CLR_SHIFT;
          end else begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        CLR_SHIFT: begin
          if (half_end && !(sample_now && !fin_ready)) begin
            tmr_reg <= '0;
            if (shift_clock_1) begin
              if (sum_reg != '0) begin
                sum_reg <= sum_reg - 1'b1;
              end else if (pix_reg == CNT_W'(1)) begin
                busy      <= 1'b0;
                state_reg <= CLR_IDLE;
              end else begin
                sum_reg <= resolution_select ? 7'h00 : sum_span;
                pix_reg <= pix_reg - 1'b1;
              end
            end
          end else if (!half_end) begin
            tmr_reg <= tmr_reg + 1'b1;
          end
        end
        default: state_reg <= CLR_IDLE;
      endcase
    end
  end

  // Sensor drive pins, all registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      transfer_gate_clock_a <= 1'b0;
      transfer_gate_clock_b <= 1'b0;
      transfer_gate_clock_c <= 1'b0;
      shift_clock_1         <= 1'b1;
      shift_clock_2         <= 1'b0;
      reset_gate_clock      <= 1'b1;
      level_clamp_clock     <= 1'b1;
    end else if (ce) begin
      // Gate follows every XFER cycle one clock late, so it lasts the full pulse count
      transfer_gate_clock_a <= (state_reg == CLR_XFER);
      transfer_gate_clock_b <= (state_reg == CLR_XFER);
      transfer_gate_clock_c <= (state_reg == CLR_XFER);
      if (state_reg == CLR_SHIFT && half_end && !(sample_now && !fin_ready)) begin
        shift_clock_1 <= !shift_clock_1;
        shift_clock_2 <= shift_clock_1;
      end else if (state_reg != CLR_SHIFT) begin
        shift_clock_1 <= 1'b1;
        shift_clock_2 <= 1'b0;
      end
      if (state_reg != CLR_SHIFT) begin
        reset_gate_clock <= 1'b1;
        if (!lclamp_reg) begin
          level_clamp_clock <= 1'b1;
        end else if (clamp_from_tg) begin
          level_clamp_clock <= (state_reg != CLR_XFER);
        end else begin
          level_clamp_clock <= 1'b0;
        end
      end else begin
        // Reset pulse at start of each summed group; skipped pulses add charge
        reset_gate_clock  <= (sum_reg == (resolution_select ? 7'h00 : sum_span)) && !shift_clock_1
                             && (tmr_reg < CNT_W'(RB_PULSE_CYC));
        level_clamp_clock <= !lclamp_reg && !shift_clock_1 && (tmr_reg < CNT_W'(RB_PULSE_CYC));
      end
    end
  end

  clr_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .ce       (ce),
    .in_valid (fin_valid),
    .in_ready (fin_ready),
    .in_data  (fin_data),
    .out_valid(fout_valid),
    .out_ready(pix_ready && !(pix_valid && !pix_ready) || !pix_valid),
    .out_data (fout_data)
  );

  // Output stage so every port is a flip-flop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_valid <= 1'b0;
      pix_data  <= '0;
      pix_last  <= 1'b0;
    end else if (ce) begin
      if (!pix_valid || pix_ready) begin
        pix_valid <= fout_valid;
        pix_data  <= fout_data[PIX_W-1:0];
        pix_last  <= fout_data[FIFO_W-1];
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/clr_ctrl_monitor.sv
// Property checker for the sensor line readout controller
`timescale 1ns/10ps
`default_nettype none
module clr_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic line_start,
  input wire logic hires_req,
  input wire logic line_clamp_req,
  input wire logic busy,
  input wire logic transfer_gate_clock_a,
  input wire logic transfer_gate_clock_b,
  input wire logic transfer_gate_clock_c,
  input wire logic shift_clock_1,
  input wire logic shift_clock_2,
  input wire logic reset_gate_clock,
  input wire logic level_clamp_clock,
  input wire logic resolution_select,
  input wire logic pix_valid,
  input wire logic pix_ready
);
  import clr_pkg::*;
  logic [8:0] gate_cnt_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Enabled cycles only, so a frozen gate is not mistaken for a long one
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) gate_cnt_reg <= 9'h0;
    else if (!transfer_gate_clock_a) gate_cnt_reg <= 9'h0;
    else if (ce) gate_cnt_reg <= gate_cnt_reg + 9'h1;
  end
  sequence s_take;
    line_start && !busy && ce;
  endsequence
  property p_take_busy;
    s_take |=> busy;
  endproperty
  a_take_busy: assert property (p_take_busy) else $error("start not taken");
  property p_take_gate;
    s_take ##1 ce |=> transfer_gate_clock_a;
  endproperty
  a_take_gate: assert property (p_take_gate) else $error("gate late");
  property p_gate_width;
    $fell(transfer_gate_clock_a) |-> gate_cnt_reg == 9'(TG_PULSE_CYC);
  endproperty
  a_gate_width: assert property (p_gate_width) else $error("gate width");
  property p_bit_clamp;
    transfer_gate_clock_a && !line_clamp_req |-> reset_gate_clock && level_clamp_clock;
  endproperty
  a_bit_clamp: assert property (p_bit_clamp) else $error("bit clamp levels");
  property p_line_clamp;
    transfer_gate_clock_a && line_clamp_req |-> reset_gate_clock && !level_clamp_clock;
  endproperty
  a_line_clamp: assert property (p_line_clamp) else $error("line clamp levels");
  property p_sel_hold;
    busy && $past(busy) |-> $stable(resolution_select);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("select moved in line");
  property p_sel_level;
    $rose(busy) |-> resolution_select == $past(hires_req);
  endproperty
  a_sel_level: assert property (p_sel_level) else $error("select level");
  property p_stream_hold;
    pix_valid && !pix_ready |=> pix_valid;
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("valid dropped");
  property p_gate_trio;
    transfer_gate_clock_b == transfer_gate_clock_a && transfer_gate_clock_c == transfer_gate_clock_a;
  endproperty
  a_gate_trio: assert property (p_gate_trio) else $error("gates differ");
  property p_shift_pair;
    shift_clock_2 == !shift_clock_1;
  endproperty
  a_shift_pair: assert property (p_shift_pair) else $error("shift clocks not complementary");
  // Shift register must stand still while charge moves in
  property p_shift_still;
    transfer_gate_clock_a |-> shift_clock_1 && !shift_clock_2;
  endproperty
  a_shift_still: assert property (p_shift_still) else $error("shift during transfer");
endmodule
bind clr_ctrl clr_ctrl_monitor u_mon (.clk_sys(clk_sys), .rst(rst), .ce(ce), .line_start(line_start),
  .hires_req(hires_req), .line_clamp_req(line_clamp_req), .busy(busy),
  .transfer_gate_clock_a(transfer_gate_clock_a), .transfer_gate_clock_b(transfer_gate_clock_b),
  .transfer_gate_clock_c(transfer_gate_clock_c), .shift_clock_1(shift_clock_1),
  .shift_clock_2(shift_clock_2), .reset_gate_clock(reset_gate_clock),
  .level_clamp_clock(level_clamp_clock), .resolution_select(resolution_select),
  .pix_valid(pix_valid), .pix_ready(pix_ready));
`default_nettype wire

// ### bench/clr_sensor_model.sv
// Behavioural model of the linear sensor output
`timescale 1ns/10ps
`default_nettype none
module clr_sensor_model (
  input  wire logic                      transfer_gate_clock_a,
  input  wire logic                      shift_clock_1,
  input  wire logic                      resolution_select,
  output logic      [clr_pkg::PIX_W-1:0] adc_data
);
  import clr_pkg::*;
  logic [14:0] pix_idx;
  logic        last_sel;
  logic        spoiled;
  initial begin
    pix_idx = 15'h0;
    last_sel = HIRES_RST;
    spoiled = 1'b0;
  end
  always @(negedge transfer_gate_clock_a) begin
    spoiled = resolution_select !== last_sel;
    last_sel = resolution_select;
    pix_idx = 15'h0;
  end
  always @(posedge shift_clock_1) pix_idx = pix_idx + 15'h1;
  // Low resolution shows only odd cells, except on a line spoiled by a select change
  always_comb begin
    if (spoiled) adc_data = {~resolution_select, ~pix_idx};
    else if (resolution_select) adc_data = {1'b1, pix_idx};
    else adc_data = {1'b0, pix_idx[13:0], 1'b1};
  end
endmodule
`default_nettype wire

// ### bench/test_clr_ctrl.sv
// Self-checking bench for the sensor line readout controller
`timescale 1ns/10ps
`default_nettype none
module test_clr_ctrl;
  import clr_pkg::*;
  logic clk_sys, rst, ce, line_start, hires_req, line_clamp_req, clamp_from_tg, pix_ready;
  logic transfer_gate_clock_a, transfer_gate_clock_b, transfer_gate_clock_c, shift_clock_1;
  logic shift_clock_2, reset_gate_clock, level_clamp_clock, resolution_select, busy, pix_valid, pix_last;
  logic [2:0]       sum_log2;
  logic [CNT_W-1:0] pixels_per_line;
  logic [PIX_W-1:0] adc_data, pix_data;
  int n_fail, tests_run;
  logic prev_sel;
  clr_ctrl dut (.clk_sys, .rst, .ce, .line_start, .hires_req, .line_clamp_req, .clamp_from_tg, .sum_log2,
    .pixels_per_line, .adc_data, .transfer_gate_clock_a, .transfer_gate_clock_b, .transfer_gate_clock_c,
    .shift_clock_1, .shift_clock_2, .reset_gate_clock, .level_clamp_clock, .resolution_select, .busy,
    .pix_valid, .pix_ready, .pix_data, .pix_last);
  clr_sensor_model sensor (.transfer_gate_clock_a, .shift_clock_1, .resolution_select, .adc_data);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One word per summed pixel; the line after a select change yields none
  function automatic int exp_words(input logic h, input int ppl);
    if (h !== prev_sel) return 0;
    return ppl;
  endfunction
  // Low resolution sums 2^s cells per word, one shift fall per cell
  function automatic int exp_falls(input logic h, input logic [2:0] s, input int ppl);
    return h ? ppl : ppl << s;
  endfunction
  // Stall holds the sink off for the first 500 cycles, too short to fill the FIFO, so shifting never freezes
  task automatic run_line(input logic h, lc, ct, input logic [2:0] s, input int ppl, input bit stall, poke);
    int n, cyc, want, falls, quiet;
    logic sc_prev;
    n = 0;
    falls = 0;
    quiet = 0;
    sc_prev = 1'b1;
    want = exp_words(h, ppl);
    @(posedge clk_sys);
    ce <= 1'b1;
    hires_req <= h;
    line_clamp_req <= lc;
    clamp_from_tg <= ct;
    sum_log2 <= s;
    pixels_per_line <= 16'(ppl);
    line_start <= 1'b1;
    @(posedge clk_sys);
    line_start <= 1'b0;
    // Quiet cycles let the last word drain out of the FIFO after busy falls
    for (cyc = 0; cyc < 30000 && quiet < 4; cyc++) begin
      @(posedge clk_sys);
      if (ce === 1'b1 && pix_valid === 1'b1 && pix_ready === 1'b1) begin
        n++;
        check(pix_data[15], h);
        if (!h) check(pix_data[0], 1'b1);
        check(pix_last, 1'(n == want));
      end
      if (sc_prev === 1'b1 && shift_clock_1 === 1'b0) falls++;
      sc_prev = shift_clock_1;
      quiet = (cyc >= 4 && busy === 1'b0 && pix_valid === 1'b0) ? quiet + 1 : 0;
      pix_ready <= stall ? (cyc > 500 && $urandom % 2 == 1) : 1'b1;
      ce <= !(stall && cyc % 97 == 50);
      line_start <= poke && cyc == 300;
    end
    check(32'(quiet), 32'h4);
    check(32'(n), 32'(want));
    check(32'(falls), 32'(exp_falls(h, s, ppl)));
    prev_sel = h;
    $display("Line done: select %0b words %0d", h, n);
  endtask
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    line_start = 1'b0;
    hires_req = 1'b1;
    line_clamp_req = 1'b0;
    clamp_from_tg = 1'b0;
    pix_ready = 1'b1;
    sum_log2 = 3'h0;
    pixels_per_line = 16'h0010;
    n_fail = 0;
    tests_run = 0;
    prev_sel = 1'b1;
    void'($urandom(32'h67ed));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    run_line(1'b1, 1'b0, 1'b0, 3'h0, 16, 1'b1, 1'b1);
    run_line(1'b1, 1'b1, 1'b1, 3'h0, 1, 1'b0, 1'b0);
    run_line(1'b0, 1'b1, 1'b0, 3'h0, 16, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++)
      run_line(1'b0, 1'($urandom), 1'($urandom), 3'($urandom % 4), 16, 1'($urandom), 1'b0);
    run_line(1'b1, 1'b0, 1'b0, 3'h5, 8, 1'b0, 1'b0);
    run_line(1'b1, 1'b0, 1'b1, 3'h7, 8, 1'b0, 1'b0);
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
